/* rtl/port3_alternate_function_mux.sv */
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "port3_mux_defines.svh"
// Overview of operation
// - Pins pull up; latch one allows input
// - Pin 0: receive, or sync data line
// - Pin 1: transmit, or sync shift clock
// - Pin 2: irq A, edge/level, two priorities
// - Irq A level gates timer A
// - Pin 3: irq B, gates timer B
// - Pin 3 MISO: master input, slave output
// - PWM outputs to port2 or port3 pair
// - Pin 4: timer A count, PWM clock
// - External clock only when config enables
// - Pin 5: timer B count input
// - Rising convert start edge starts conversion
module port3_alternate_function_mux
  import port3_mux_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port3_in,
  output logic [7:0]       port3_out,
  output logic [7:0]       port3_oe,
  output logic             port2_pin_6_out,
  output logic             port2_pin_7_out,
  output logic             port2_pwm_sel,
  input  wire periph_out_s periph_out,
  output periph_in_s       periph_in,
  output logic             external_irq_a_req,
  output logic             external_irq_b_req,
  output logic             external_irq_a_high_prio,
  output logic             external_irq_b_high_prio,
  output logic             timer_a_gate,
  output logic             timer_b_gate,
  output logic             convert_start,
  output logic             irq
);

  // ============================================================
  // Registers and events
  logic [7:0] latch;
  logic [4:0] config_bits;
  logic [3:0] irq_ctl;
  logic [2:0] irq_mask;
  logic [2:0] irq_status;
  logic [2:0] events;
  logic       fall_a;
  logic       fall_b;
  logic       rise_cs;

  port3_apb_regs u_regs (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pin_level    (port3_in),
    .events       (events),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .latch        (latch),
    .config_bits  (config_bits),
    .irq_ctl      (irq_ctl),
    .irq_mask     (irq_mask),
    .irq_status   (irq_status),
    .periph_state ()
  );

  port3_edge_detect u_edge_a (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (port3_in[2]),
    .rise    (),
    .fall    (fall_a)
  );

  port3_edge_detect u_edge_b (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (port3_in[3]),
    .rise    (),
    .fall    (fall_b)
  );

  port3_edge_detect u_edge_cs (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (port3_in[5]),
    .rise    (rise_cs),
    .fall    ()
  );

  logic external_clock_input_en;
  logic pwm_on_p3;
  logic convert_start_input_en;
  logic pulse_width_clock_input_sel;
  logic miso_en;
  logic uart_sync;
  logic spi_master;
  assign external_clock_input_en  = config_bits[`CFG_EXTERNAL_CLOCK_INPUT_EN_BIT];
  assign pwm_on_p3  = config_bits[`CFG_PWM_ROUTE_BIT];
  assign convert_start_input_en  = config_bits[`CFG_CONVERT_START_INPUT_EN_BIT];
  assign pulse_width_clock_input_sel   = config_bits[`CFG_PULSE_WIDTH_CLOCK_INPUT_SEL_BIT];
  assign miso_en    = config_bits[`CFG_MISO_EN_BIT];
  assign uart_sync  = periph_out.uart_sync_mode;
  assign spi_master = periph_out.spi_master;

  // ============================================================
  // Interrupt trigger: edge = falling, level = low
  logic trig_a;
  logic trig_b;
  assign trig_a = irq_ctl[`IRQ_A_EDGE_BIT] ? fall_a : ~port3_in[2];
  assign trig_b = irq_ctl[`IRQ_B_EDGE_BIT] ? fall_b : ~port3_in[3];
  assign events = {rise_cs & convert_start_input_en, trig_b, trig_a};

  // ============================================================
  // Alternate output selection per pin
  logic [7:0] alt_out;

  // Pins with no alternate output keep a one, so the latch alone decides
  always_comb
  begin
    alt_out = 8'hFF;
    if (uart_sync)
    begin
      alt_out[0] = periph_out.uart_sync_data_out;
      alt_out[1] = periph_out.uart_shift_clk;
    end
    else
      alt_out[1] = periph_out.uart_tx;
    if (pwm_on_p3)
    begin
      alt_out[3] = periph_out.pulse_width_out_b;
      alt_out[4] = periph_out.pulse_width_out_a;
    end
    else if (miso_en & ~spi_master)
      alt_out[3] = periph_out.spi_miso_out;
    // External clock owns pin 4 as input; no PWM drive, the latch alone decides
    if (external_clock_input_en)
      alt_out[4] = 1'b1;
  end

  // ============================================================
  // Quasi-bidirectional drive: strong low only, pull-up for high.
  // Output enable marks the strong low; a one relies on the pull-up.
  logic [7:0] pin_value;
  assign pin_value = latch & alt_out;
  assign port3_out = 8'h00;
  assign port3_oe  = ~pin_value;

  assign port2_pin_6_out = periph_out.pulse_width_out_a;
  assign port2_pin_7_out = periph_out.pulse_width_out_b;
  assign port2_pwm_sel   = ~pwm_on_p3;

  // ============================================================
  // Inputs to peripherals
  always_comb
  begin
    periph_in.uart_rx             = port3_in[0];
    periph_in.external_irq_a      = port3_in[2];
    periph_in.external_irq_b      = port3_in[3];
    periph_in.spi_miso_in         = spi_master & miso_en
                                    & port3_in[3];
    periph_in.timer_a_count_input = port3_in[4];
    periph_in.pulse_width_clock_input = pulse_width_clock_input_sel
                                    & port3_in[4];
    periph_in.external_clock_input = external_clock_input_en
                                    & port3_in[4];
    periph_in.timer_b_count_input = port3_in[5];
  end

  // Gate is the raw pin level, high enables counting
  assign timer_a_gate = port3_in[2];
  assign timer_b_gate = port3_in[3];

  assign external_irq_a_req       = trig_a;
  assign external_irq_b_req       = trig_b;
  assign external_irq_a_high_prio = irq_ctl[`IRQ_A_PRIO_BIT];
  assign external_irq_b_high_prio = irq_ctl[`IRQ_B_PRIO_BIT];

  // One-cycle pulse on a qualified rising edge
  assign convert_start = rise_cs & convert_start_input_en;

  assign irq = |(irq_status & irq_mask);

endmodule

/* include/port3_mux_defines.svh */
`ifndef PORT3_MUX_DEFINES_SVH
`define PORT3_MUX_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses)
`define P3_LATCH_OFFSET   12'h000
`define P3_PIN_OFFSET     12'h004
`define P3_CONFIG_OFFSET  12'h008
`define P3_IRQCTL_OFFSET  12'h00C
`define P3_STATUS_OFFSET  12'h010
`define P3_MASK_OFFSET    12'h014
`define P3_PERIPH_OFFSET  12'h018

// ============================================================
// Config register field positions
`define CFG_EXTERNAL_CLOCK_INPUT_EN_BIT   0
`define CFG_PWM_ROUTE_BIT   1
`define CFG_CONVERT_START_INPUT_EN_BIT   2
`define CFG_PULSE_WIDTH_CLOCK_INPUT_SEL_BIT    3
`define CFG_MISO_EN_BIT     4

// ============================================================
// Irq control field positions
`define IRQ_A_EDGE_BIT  0
`define IRQ_A_PRIO_BIT  1
`define IRQ_B_EDGE_BIT  2
`define IRQ_B_PRIO_BIT  3

// ============================================================
// Peripheral state field positions
`define PER_UART_SYNC_BIT   0
`define PER_SPI_MASTER_BIT  1

// ============================================================
// Status bit positions
`define ST_IRQ_A_BIT    0
`define ST_IRQ_B_BIT    1
`define ST_CONVERT_START_INPUT_BIT   2

// ============================================================
// Reset values
`define P3_LATCH_RESET   8'hFF
`define P3_CONFIG_RESET  5'h00
`define P3_IRQCTL_RESET  4'h0
`define P3_MASK_RESET    3'h0
`define P3_PERIPH_RESET  2'h0

`endif

/* include/port3_mux_pkg.sv */
package port3_mux_pkg;

  typedef struct packed {
    logic       uart_tx;
    logic       uart_shift_clk;
    logic       uart_sync_data_out;
    logic       uart_sync_mode;
    logic       spi_miso_out;
    logic       spi_master;
    logic       pulse_width_out_a;
    logic       pulse_width_out_b;
  } periph_out_s;

  typedef struct packed {
    logic       uart_rx;
    logic       external_irq_a;
    logic       external_irq_b;
    logic       timer_a_count_input;
    logic       timer_b_count_input;
    logic       pulse_width_clock_input;
    logic       external_clock_input;
    logic       spi_miso_in;
  } periph_in_s;

  typedef enum logic [1:0] {
    IRQ_IDLE  = 2'b01,
    IRQ_WRITE = 2'b10
  } apb_phase_e;

endpackage

/* rtl/port3_edge_detect.sv */
`timescale 1ns/1ps
module port3_edge_detect
  import port3_mux_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
  } edge_state_s;

  edge_state_s state;
  edge_state_s next_state;

  always_comb
  begin
    next_state      = state;
    next_state.prev = level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '{prev: 1'b1};
    else
      state <= next_state;
  end

  // Reset value of one matches the pull-up idle level
  assign rise = level & ~state.prev;
  assign fall = ~level & state.prev;

endmodule

/* rtl/port3_apb_regs.sv */
`timescale 1ns/1ps
`include "port3_mux_defines.svh"
module port3_apb_regs
  import port3_mux_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [7:0]  pin_level,
  input  wire logic [2:0]  events,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [7:0]       latch,
  output logic [4:0]       config_bits,
  output logic [3:0]       irq_ctl,
  output logic [2:0]       irq_mask,
  output logic [2:0]       irq_status,
  output logic [1:0]       periph_state
);

  typedef struct packed {
    logic [7:0]  latch;
    logic [4:0]  cfg;
    logic [3:0]  irqctl;
    logic [2:0]  mask;
    logic [2:0]  status;
    logic [1:0]  periph;
    logic [31:0] rdata;
    logic        err;
  } reg_state_s;

  reg_state_s state;
  reg_state_s next_state;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `P3_LATCH_OFFSET)  || (a == `P3_PIN_OFFSET)   ||
                (a == `P3_CONFIG_OFFSET) || (a == `P3_IRQCTL_OFFSET) ||
                (a == `P3_STATUS_OFFSET) || (a == `P3_MASK_OFFSET)  ||
                (a == `P3_PERIPH_OFFSET);
  endfunction

  logic setup;
  logic wr;
  logic rd;
  assign setup = psel & ~penable;
  assign wr    = setup & pwrite & is_mapped(paddr);
  assign rd    = setup & ~pwrite;

  // ============================================================
  // Register update, data captured in setup, answered in access
  always_comb
  begin
    next_state     = state;
    next_state.err = 1'b0;
    if (setup)
    begin
      next_state.err   = ~is_mapped(paddr);
      next_state.rdata = 32'h0000_0000;
    end
    if (wr)
    begin
      unique case (paddr)
        `P3_LATCH_OFFSET:  next_state.latch  = pwdata[7:0];
        `P3_CONFIG_OFFSET: next_state.cfg    = pwdata[4:0];
        `P3_IRQCTL_OFFSET: next_state.irqctl = pwdata[3:0];
        `P3_MASK_OFFSET:   next_state.mask   = pwdata[2:0];
        `P3_PERIPH_OFFSET: next_state.periph = pwdata[1:0];
        default:           next_state.latch  = state.latch;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        `P3_LATCH_OFFSET:  next_state.rdata = {24'h0, state.latch};
        `P3_PIN_OFFSET:    next_state.rdata = {24'h0, pin_level};
        `P3_CONFIG_OFFSET: next_state.rdata = {27'h0, state.cfg};
        `P3_IRQCTL_OFFSET: next_state.rdata = {28'h0, state.irqctl};
        `P3_STATUS_OFFSET: next_state.rdata = {29'h0, state.status};
        `P3_MASK_OFFSET:   next_state.rdata = {29'h0, state.mask};
        `P3_PERIPH_OFFSET: next_state.rdata = {30'h0, state.periph};
        default:           next_state.rdata = 32'h0000_0000;
      endcase
      // Read clears status; a same-cycle event still sets it below
      if (paddr == `P3_STATUS_OFFSET)
        next_state.status = 3'h0;
    end
    next_state.status = next_state.status | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= '0;
      state.latch  <= `P3_LATCH_RESET;
      state.cfg    <= `P3_CONFIG_RESET;
      state.irqctl <= `P3_IRQCTL_RESET;
      state.mask   <= `P3_MASK_RESET;
      state.periph <= `P3_PERIPH_RESET;
    end
    else
      state <= next_state;
  end

  assign prdata       = state.rdata;
  assign pready       = psel & penable;
  assign pslverr      = psel & penable & state.err;
  assign latch        = state.latch;
  assign config_bits  = state.cfg;
  assign irq_ctl      = state.irqctl;
  assign irq_mask     = state.mask;
  assign irq_status   = state.status;
  assign periph_state = state.periph;

endmodule

/* bench/port3_mux_monitor.sv */
`timescale 1ns/1ps
`include "port3_mux_defines.svh"
module port3_mux_monitor
  import port3_mux_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0]  port3_in,
  input wire logic [7:0]  port3_out,
  input wire logic [7:0]  port3_oe,
  input wire logic        port2_pwm_sel,
  input wire periph_out_s periph_out,
  input wire periph_in_s  periph_in,
  input wire logic        external_irq_a_req,
  input wire logic        external_irq_a_high_prio,
  input wire logic        timer_a_gate,
  input wire logic        timer_b_gate,
  input wire logic        convert_start
);
  // ============================================================
  // Register shadows
  logic [7:0] lat;
  logic [4:0] cfg;
  logic [3:0] ictl;
  // Setup-cycle writes take effect, as in the slave
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lat  <= `P3_LATCH_RESET;
      cfg  <= `P3_CONFIG_RESET;
      ictl <= `P3_IRQCTL_RESET;
    end
    else if (psel && !penable && pwrite)
    begin
      if (paddr == `P3_LATCH_OFFSET)
        lat <= pwdata[7:0];
      if (paddr == `P3_CONFIG_OFFSET)
        cfg <= pwdata[4:0];
      if (paddr == `P3_IRQCTL_OFFSET)
        ictl <= pwdata[3:0];
    end
  // ============================================================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_pull;
    port3_out == 8'h00 && port3_oe[7:5] == ~lat[7:5]
      && port3_oe[2] == !lat[2];
  endproperty
  a_pull: assert property (p_pull)
    else $error("pin drive wrong");
  property p_rx;
    periph_in.uart_rx == port3_in[0]
      && periph_in.external_irq_a == port3_in[2];
  endproperty
  a_rx: assert property (p_rx)
    else $error("rx wrong");
  property p_tx;
    port3_oe[1] == !(lat[1] && (periph_out.uart_sync_mode ?
      periph_out.uart_shift_clk : periph_out.uart_tx));
  endproperty
  a_tx: assert property (p_tx)
    else $error("pin 1 drive wrong");
  property p_lvl;
    external_irq_a_high_prio == ictl[1]
      && (ictl[0] || external_irq_a_req == !port3_in[2]);
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("irq a level wrong");
  property p_pulse;
    ictl[0] && external_irq_a_req |=> !external_irq_a_req || !ictl[0];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("irq a pulse long");
  property p_gate;
    timer_a_gate == port3_in[2] && timer_b_gate == port3_in[3]
      && periph_in.external_irq_b == port3_in[3]
      && periph_in.timer_a_count_input == port3_in[4]
      && periph_in.timer_b_count_input == port3_in[5];
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate or count wrong");
  property p_miso;
    periph_in.spi_miso_in == (port3_in[3] && periph_out.spi_master
      && cfg[4]);
  endproperty
  a_miso: assert property (p_miso)
    else $error("miso in wrong");
  property p_route;
    port2_pwm_sel == !cfg[1];
  endproperty
  a_route: assert property (p_route)
    else $error("pwm route wrong");
  property p_clk;
    periph_in.external_clock_input == (port3_in[4] && cfg[0])
      && periph_in.pulse_width_clock_input == (port3_in[4] && cfg[3])
      && (!cfg[0] || port3_oe[4] == !lat[4]);
  endproperty
  a_clk: assert property (p_clk)
    else $error("pin 4 clock wrong");
  property p_conv;
    convert_start |-> cfg[2] ##1 !convert_start;
  endproperty
  a_conv: assert property (p_conv)
    else $error("convert start wrong");
  c_conv: cover property (convert_start);
  c_edge: cover property (ictl[0] && external_irq_a_req);
  c_route: cover property (cfg[1] && !port3_oe[3]);
endmodule
bind port3_alternate_function_mux port3_mux_monitor u_mon (
  .pclk                     (pclk),
  .presetn                  (presetn),
  .psel                     (psel),
  .penable                  (penable),
  .pwrite                   (pwrite),
  .paddr                    (paddr),
  .pwdata                   (pwdata),
  .port3_in                 (port3_in),
  .port3_out                (port3_out),
  .port3_oe                 (port3_oe),
  .port2_pwm_sel            (port2_pwm_sel),
  .periph_out               (periph_out),
  .periph_in                (periph_in),
  .external_irq_a_req       (external_irq_a_req),
  .external_irq_a_high_prio (external_irq_a_high_prio),
  .timer_a_gate             (timer_a_gate),
  .timer_b_gate             (timer_b_gate),
  .convert_start            (convert_start)
);

/* bench/port3_board.sv */
`timescale 1ns/1ps
module port3_board
(
  input  wire logic [7:0] port3_out,
  input  wire logic [7:0] port3_oe,
  input  wire logic [7:0] ext_low,
  output logic [7:0]      port3_in
);
  // ============================================================
  // Wired pins: weak pull-up unless a side pulls low
  assign port3_in = ~ext_low & ~(port3_oe & ~port3_out);
endmodule

/* bench/port3_alternate_function_mux_bench.sv */
`timescale 1ns/1ps
`include "port3_mux_defines.svh"
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, v); end end
module port3_alternate_function_mux_bench
  import port3_mux_pkg::*;
  ;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  ext_low = 8'h00;
  // Transmit line idles high, as a quiet serial port leaves it
  periph_out_s periph_out = '{uart_tx: 1'b1, default: 1'b0};
  logic [31:0] prdata, rd;
  logic [7:0]  port3_in, port3_out, port3_oe;
  logic        pready, pslverr, serr, irq, convert_start;
  logic        port2_pin_6_out, port2_pin_7_out, port2_pwm_sel;
  logic        external_irq_a_req, external_irq_b_req;
  logic        external_irq_a_high_prio, external_irq_b_high_prio;
  logic        timer_a_gate, timer_b_gate;
  periph_in_s  periph_in;
  int          miscompares = 0, check_count = 0, cyc = 0;
  int          n_a = 0, n_c = 0, k;
  logic [11:0] offs [7] = '{`P3_LATCH_OFFSET, `P3_PIN_OFFSET,
    `P3_CONFIG_OFFSET, `P3_IRQCTL_OFFSET, `P3_STATUS_OFFSET,
    `P3_MASK_OFFSET, `P3_PERIPH_OFFSET};
  logic [31:0] rstv [7] = '{32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};

  port3_alternate_function_mux uut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .port3_in                 (port3_in),
    .port3_out                (port3_out),
    .port3_oe                 (port3_oe),
    .port2_pin_6_out          (port2_pin_6_out),
    .port2_pin_7_out          (port2_pin_7_out),
    .port2_pwm_sel            (port2_pwm_sel),
    .periph_out               (periph_out),
    .periph_in                (periph_in),
    .external_irq_a_req       (external_irq_a_req),
    .external_irq_b_req       (external_irq_b_req),
    .external_irq_a_high_prio (external_irq_a_high_prio),
    .external_irq_b_high_prio (external_irq_b_high_prio),
    .timer_a_gate             (timer_a_gate),
    .timer_b_gate             (timer_b_gate),
    .convert_start            (convert_start),
    .irq                      (irq)
  );
  port3_board board (
    .port3_out (port3_out),
    .port3_oe  (port3_oe),
    .ext_low   (ext_low),
    .port3_in  (port3_in)
  );

  always #20 pclk = ~pclk;
  // ============================================================
  // Pulse counters and hang guard
  always @(posedge pclk)
  begin
    n_a <= n_a + external_irq_a_req;
    n_c <= n_c + convert_start;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ============================================================
  // Bus tasks
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd   = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps two requests from landing in one step
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK($sformatf("reg %0h", a), e, rd)
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask
  // ============================================================
  // Tests
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i])
      rd_chk(offs[i], rstv[i]);
    xfer(1'b1, 12'h040, 32'hFF);
    `CHK("unmapped err", 1'b1, serr)
    rd_chk(12'h040, 32'h0);
    xfer(1'b1, `P3_PIN_OFFSET, 32'h0);
    xfer(1'b1, `P3_PERIPH_OFFSET, 32'h3);
    rd_chk(`P3_PERIPH_OFFSET, 32'h3);
    ext_low <= 8'h80;
    settle();
    rd_chk(`P3_PIN_OFFSET, 32'h7F);
    ext_low <= 8'h00;
    xfer(1'b1, `P3_LATCH_OFFSET, 32'h7F);
    `CHK("latch drive", 8'h80, port3_oe)
    rd_chk(`P3_PIN_OFFSET, 32'h7F);
    xfer(1'b1, `P3_LATCH_OFFSET, 32'hFF);
    periph_out.uart_tx <= 1'b0;
    ext_low <= 8'h01;
    settle();
    `CHK("tx", 2'b00, port3_in[1:0])
    periph_out <= '{uart_tx: 1, uart_sync_mode: 1, default: 0};
    ext_low <= 8'h00;
    settle();
    `CHK("sync low", 2'b00, port3_in[1:0])
    periph_out.uart_shift_clk <= 1'b1;
    periph_out.uart_sync_data_out <= 1'b1;
    settle();
    `CHK("sync high", 2'b11, port3_in[1:0])
    xfer(1'b1, `P3_LATCH_OFFSET, 32'hFD);
    `CHK("latch and", 1'b0, port3_in[1])
    xfer(1'b1, `P3_LATCH_OFFSET, 32'hFF);
    xfer(1'b1, `P3_MASK_OFFSET, 32'h7);
    ext_low <= 8'h0C;
    settle();
    `CHK("level", 4'hC, {external_irq_a_req, external_irq_b_req,
      timer_a_gate, timer_b_gate})
    `CHK("irq set", 1'b1, irq)
    ext_low <= 8'h00;
    settle();
    rd_chk(`P3_STATUS_OFFSET, 32'h3);
    rd_chk(`P3_STATUS_OFFSET, 32'h0);
    `CHK("irq clear", 1'b0, irq)
    xfer(1'b1, `P3_MASK_OFFSET, 32'h0);
    xfer(1'b1, `P3_IRQCTL_OFFSET, 32'hF);
    `CHK("prio", 2'b11, {external_irq_a_high_prio,
      external_irq_b_high_prio})
    k = n_a;
    ext_low <= 8'h04;
    settle();
    `CHK("edge pulse", k + 1, n_a)
    `CHK("irq masked", 1'b0, irq)
    xfer(1'b1, `P3_MASK_OFFSET, 32'h1);
    `CHK("irq unmasked", 1'b1, irq)
    rd_chk(`P3_STATUS_OFFSET, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
    ext_low <= 8'h00;
    settle();
    xfer(1'b1, `P3_IRQCTL_OFFSET, 32'h0);
    xfer(1'b1, `P3_CONFIG_OFFSET, 32'h10);
    periph_out.spi_master <= 1'b1;
    ext_low <= 8'h08;
    settle();
    `CHK("miso low", 1'b0, periph_in.spi_miso_in)
    ext_low <= 8'h00;
    settle();
    `CHK("miso high", 1'b1, periph_in.spi_miso_in)
    periph_out.spi_master <= 1'b0;
    settle();
    `CHK("miso out", 1'b1, port3_oe[3])
    xfer(1'b1, `P3_CONFIG_OFFSET, 32'h2);
    periph_out.pulse_width_out_b <= 1'b1;
    settle();
    `CHK("pwm port3", 3'b001, {port2_pwm_sel, port3_in[4:3]})
    xfer(1'b1, `P3_CONFIG_OFFSET, 32'h0);
    `CHK("pwm port2", 5'h1B, {port2_pwm_sel, port2_pin_7_out,
      port2_pin_6_out, port3_in[4:3]})
    xfer(1'b1, `P3_CONFIG_OFFSET, 32'hB);
    ext_low <= 8'h10;
    settle();
    `CHK("pin4 low", 3'b000, {periph_in.external_clock_input,
      periph_in.pulse_width_clock_input,
      periph_in.timer_a_count_input})
    ext_low <= 8'h00;
    settle();
    `CHK("pin4 high", 4'h7, {port3_oe[4], periph_in.external_clock_input,
      periph_in.pulse_width_clock_input,
      periph_in.timer_a_count_input})
    xfer(1'b1, `P3_CONFIG_OFFSET, 32'h4);
    `CHK("external_clock_input off", 1'b0, periph_in.external_clock_input)
    xfer(1'b0, `P3_STATUS_OFFSET, 32'h0);
    ext_low <= 8'h20;
    settle();
    `CHK("timer b", 1'b0, periph_in.timer_b_count_input)
    k = n_c;
    ext_low <= 8'h00;
    settle();
    `CHK("convert", k + 1, n_c)
    rd_chk(`P3_STATUS_OFFSET, 32'h4);
    xfer(1'b1, `P3_CONFIG_OFFSET, 32'h0);
    ext_low <= 8'h20;
    settle();
    k = n_c;
    ext_low <= 8'h00;
    settle();
    `CHK("no convert", k, n_c)
    conclude();
  end
endmodule
